// [shared/tsr_pkg.sv]
// constants of the timer trigger source router: register map, field layout, reset values
// assumes a 32-bit APB register bus and 7-bit select codes
package tsr_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int           TSR_ADDR_W      = 8;
   localparam logic [7:0]   TSR_OFS_BREAK   = 8'h28;
   localparam logic [7:0]   TSR_OFS_TRIG    = 8'h2C;
   localparam logic [31:0]  TSR_RST_BREAK   = 32'h39393939;
   localparam logic [31:0]  TSR_RST_TRIG    = 32'h15151515;

   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int           TSR_SEL_W       = 7;
   localparam int           TSR_OUTS        = 4;
   localparam int           TSR_FIELD_PITCH = 8;
   localparam int           TSR_LOCK_BIT    = 31;
   localparam logic [31:0]  TSR_LOCK_MASK   = 32'h80000000;
   localparam logic [31:0]  TSR_SEL_MASK    = 32'h7F7F7F7F;
   localparam logic [31:0]  TSR_ZERO        = 32'h00000000;

endpackage : tsr_pkg

// [hw/tsr_router.sv]
// timer trigger source router: two lockable routing registers behind an APB slave
// assumes the trigger sources come from logic on sys_clk, so they are not synchronised
//
// Design decision made here: the APB interface to the registers.
module tsr_router
   import tsr_pkg::*;
#(
   parameter int NUM_SRC = 128
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [TSR_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // internal trigger sources
   input  wire logic [NUM_SRC-1:0]     trigSrc,
   // first timer break inputs, bit n is break input n
   output logic [TSR_OUTS-1:0]         firstTimerBreakIn,
   // second timer internal trigger inputs, bit n is trigger input n
   output logic [TSR_OUTS-1:0]         secondTimerTrigIn
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [TSR_SEL_W-1:0] selField(input logic [31:0] regVal, input int n);
      selField = regVal[n*TSR_FIELD_PITCH +: TSR_SEL_W];
   endfunction : selField

   // next register value: lock is sticky, reserved bits stay zero
   function automatic logic [31:0] nextVal(input logic [31:0] cur, input logic [31:0] wd);
      nextVal = (wd & (TSR_SEL_MASK | TSR_LOCK_MASK)) | (cur & TSR_LOCK_MASK);
   endfunction : nextVal

   function automatic logic routeBit(input logic [NUM_SRC-1:0] src,
                                     input logic [TSR_SEL_W-1:0] code);
      routeBit = (int'(code) < NUM_SRC) ? src[code] : 1'b0;
   endfunction : routeBit

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic [31:0]         breakSel_r;
   logic [31:0]         trigger_selection_unit_r;
   logic [31:0]         breakSel_nxt;
   logic [31:0]         trigger_selection_unit_nxt;
   logic                pready_r;
   logic                pslverr_r;
   logic [31:0]         prdata_r;
   logic [TSR_OUTS-1:0] breakOut_r;
   logic [TSR_OUTS-1:0] trigOut_r;

   wire logic        setupPhase = psel & ~penable;
   wire logic        hitBreak   = (paddr == TSR_OFS_BREAK);
   wire logic        hitTrig    = (paddr == TSR_OFS_TRIG);
   wire logic        mapped     = hitBreak | hitTrig;
   wire logic        wrAccept   = psel & penable & pready_r & pwrite;
   wire logic        breakLock  = breakSel_r[TSR_LOCK_BIT];
   wire logic        trigLock   = trigger_selection_unit_r[TSR_LOCK_BIT];
   wire logic        wrBreak    = wrAccept & hitBreak & ~breakLock;
   wire logic        wrTrig     = wrAccept & hitTrig & ~trigLock;
   wire logic [31:0] rdMux      = hitBreak ? breakSel_r : (hitTrig ? trigger_selection_unit_r : TSR_ZERO);

   assign breakSel_nxt = wrBreak ? nextVal(breakSel_r, pwdata) : breakSel_r;
   assign trigger_selection_unit_nxt  = wrTrig  ? nextVal(trigger_selection_unit_r, pwdata)  : trigger_selection_unit_r;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         breakSel_r <= TSR_RST_BREAK;
         trigger_selection_unit_r  <= TSR_RST_TRIG;
      end else begin
         breakSel_r <= breakSel_nxt;
         trigger_selection_unit_r  <= trigger_selection_unit_nxt;
      end
   end

   // answer in the cycle after setup, no wait states
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= TSR_ZERO;
      end else begin
         pready_r  <= setupPhase;
         pslverr_r <= setupPhase & ~mapped;
         prdata_r  <= (setupPhase & ~pwrite) ? rdMux : TSR_ZERO;
      end
   end

   // ----------------------------------------
   // routing
   // ----------------------------------------
   // field n drives output n: 6:0, 14:8, 22:16, 30:24
   wire logic [TSR_SEL_W-1:0] breakCode0 = selField(breakSel_r, 0);
   wire logic [TSR_SEL_W-1:0] breakCode1 = selField(breakSel_r, 1);
   wire logic [TSR_SEL_W-1:0] breakCode2 = selField(breakSel_r, 2);
   wire logic [TSR_SEL_W-1:0] breakCode3 = selField(breakSel_r, 3);
   wire logic [TSR_SEL_W-1:0] trigCode0  = selField(trigger_selection_unit_r, 0);
   wire logic [TSR_SEL_W-1:0] trigCode1  = selField(trigger_selection_unit_r, 1);
   wire logic [TSR_SEL_W-1:0] trigCode2  = selField(trigger_selection_unit_r, 2);
   wire logic [TSR_SEL_W-1:0] trigCode3  = selField(trigger_selection_unit_r, 3);

   wire logic [TSR_OUTS-1:0]  breakRoute = {routeBit(trigSrc, breakCode3),
                                            routeBit(trigSrc, breakCode2),
                                            routeBit(trigSrc, breakCode1),
                                            routeBit(trigSrc, breakCode0)};
   wire logic [TSR_OUTS-1:0]  trigRoute  = {routeBit(trigSrc, trigCode3),
                                            routeBit(trigSrc, trigCode2),
                                            routeBit(trigSrc, trigCode1),
                                            routeBit(trigSrc, trigCode0)};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         breakOut_r <= '0;
         trigOut_r  <= '0;
      end else begin
         breakOut_r <= breakRoute;
         trigOut_r  <= trigRoute;
      end
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign firstTimerBreakIn = breakOut_r;
   assign secondTimerTrigIn = trigOut_r;

endmodule : tsr_router

// [testbench/tsr_timer_model.sv]
// far-side timer inputs: samples both output groups each clock
// assumes the timer runs on the router clock
module tsr_timer_model (
   input  wire logic       sys_clk,
   input  wire logic [3:0] firstTimerBreakIn,
   input  wire logic [3:0] secondTimerTrigIn,
   output logic      [7:0] seen
);
   always_ff @(posedge sys_clk) seen <= {firstTimerBreakIn, secondTimerTrigIn};
endmodule : tsr_timer_model

// [testbench/tsr_router_props.sv]
// port checker for tsr_router
// assumes one clock, async active-high reset
module tsr_router_props
   import tsr_pkg::*;
#(parameter int NUM_SRC = 128) (
   input wire logic sys_clk, rst, psel, penable, pwrite, pready, pslverr,
   input wire logic [TSR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic [NUM_SRC-1:0] trigSrc,
   input wire logic [3:0] firstTimerBreakIn, secondTimerTrigIn
);
   logic wr_r, lock_r;
   wire acc = psel && penable && pready;
   wire isT = paddr == TSR_OFS_TRIG;
   always_ff @(posedge sys_clk or posedge rst)
      if (rst) {wr_r, lock_r} <= 2'h0;
      else {wr_r, lock_r} <= {wr_r | (acc & pwrite), lock_r | (acc & !pwrite & isT & prdata[31])};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
   rdy_one_cycle_a: assert property (pready |=> !pready) else $error("long ready");
   err_unmapped_a: assert property (pready |-> pslverr == !(isT || paddr == TSR_OFS_BREAK))
      else $error("bad slverr");
   rsvd_zero_a: assert property (acc && !pwrite |-> !(prdata & 32'h00808080))
      else $error("reserved set");
   lock_sticky_a: assert property (acc && !pwrite && isT && lock_r |-> prdata[31])
      else $error("lock cleared");
   brk_route_a: assert property (!wr_r && !$past(rst) |->
      firstTimerBreakIn == {4{$past(trigSrc[8'h39])}})
      else $error("break route");
   trg_route_a: assert property (!wr_r && !$past(rst) |->
      secondTimerTrigIn == {4{$past(trigSrc[8'h15])}})
      else $error("trig route");
   idle_rdata_a: assert property (!acc |-> prdata == 32'h0) else $error("rdata idle");
endmodule : tsr_router_props
bind tsr_router tsr_router_props #(.NUM_SRC(NUM_SRC)) props_i (.*);

// [testbench/tsr_router_test.sv]
// self-checking bench for tsr_router over APB
// assumes a 40 MHz clock and NUM_SRC of 128
module tsr_router_test;
   import tsr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errSeen;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [127:0] trigSrc = 128'h8000_0000_0000_0000_0000_0000_0000_008B;
   logic [3:0] firstTimerBreakIn, secondTimerTrigIn;
   logic [7:0] farSeen;
   int failures = 0, total_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   tsr_router dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                   .pslverr, .trigSrc, .firstTimerBreakIn, .secondTimerTrigIn);
   tsr_timer_model far (.sys_clk, .firstTimerBreakIn, .secondTimerTrigIn, .seen(farSeen));
   task chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task xfer(logic w, logic [7:0] a, logic [31:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge sys_clk) penable <= 1;
      @(posedge sys_clk) while (pready !== 1'b1) @(posedge sys_clk);
      {rd, errSeen} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
      @(posedge sys_clk);
   endtask : xfer
   task end_of_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      xfer(0, TSR_OFS_BREAK, 0); chk("brk rst", rd, TSR_RST_BREAK);
      xfer(0, TSR_OFS_TRIG, 0); chk("trg rst", rd, TSR_RST_TRIG);
      xfer(1, TSR_OFS_BREAK, 32'h03027F01);
      xfer(0, TSR_OFS_BREAK, 0); chk("brk wr", rd, 32'h03027F01);
      xfer(1, TSR_OFS_TRIG, 32'h80050607);
      xfer(1, TSR_OFS_TRIG, 32'h00010101);
      xfer(0, TSR_OFS_TRIG, 0); chk("trg lock", rd, 32'h80050607);
      for (int i = 0; i < 2; i++) begin
         trigSrc <= i ? 128'h7FFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FF74 : trigSrc;
         repeat (3) @(posedge sys_clk);
         chk("brk out", 32'(firstTimerBreakIn), i ? 32'h4 : 32'hB);
         chk("trg out", 32'(secondTimerTrigIn), i ? 32'h6 : 32'h9);
      end
      chk("far seen", 32'(farSeen), 32'h46);
      xfer(1, 8'h30, 32'h1);
      xfer(0, 8'h30, 0); chk("unmapped", {rd[30:0], errSeen}, 32'h1);
      rst <= 1;
      @(posedge sys_clk) rst <= 0;
      @(posedge sys_clk);
      xfer(1, TSR_OFS_TRIG, 32'h00010101);
      xfer(0, TSR_OFS_TRIG, 0); chk("unlock", rd, 32'h00010101);
      end_of_test();
   end
endmodule : tsr_router_test
